// ===== bench/flash_host.sv
// Host model that drives the serial command link of the protection block
`timescale 1ns/100ps
`default_nettype none
module flash_host (
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  // Deselected and idle; the short wait lets the select edge reach the
  // device's frame logic only once its processes are waiting on it
  initial begin
    #1;
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b1;
  end
  // ---------------------------------------------------------------
  // One frame: clock idles low outside frames, 15 ns period inside
  // ---------------------------------------------------------------
  task automatic xfer(input logic [39:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = tx[39 - i];  // MSB first, changed while clock is low
      #7.5 serial_clock = 1'b1;
      rx = {rx[14:0], serial_data_out};  // Device output moved on the falling edge
      #7.5 serial_clock = 1'b0;
    end
    #7.5 chip_select_n = 1'b1;
    // A released line must not keep showing the last bit
    serial_data_in = ~serial_data_in;
    #200;  // Gap well above the three system clocks the select sync needs
  endtask
endmodule  // flash_host
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the status register and sector protection block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import flash_sp_pkg::*;
  logic clk, rst, serial_clock, chip_select_n, serial_data_in, serial_data_out, serial_data_oe;
  logic array_busy, array_write_go, array_sector_erase_go, array_bulk_erase_go;
  logic [23:0] array_addr;
  logic [7:0] array_data, flash_status_protection;
  logic [15:0] rx;
  int failures = 0, total_checks = 0, cycles = 0;
  int n_wr = 0, n_se = 0, n_be = 0, e_wr = 0, e_se = 0, e_be = 0;

  flash_status_block_protect #(.SECTORS(DENS_S), .WS_CYCLES_P(20)) u_flash_status_block_protect (
    .clk(clk), .rst(rst), .serial_clock(serial_clock), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .array_busy(array_busy),
    .array_write_go(array_write_go), .array_sector_erase_go(array_sector_erase_go),
    .array_bulk_erase_go(array_bulk_erase_go), .array_addr(array_addr),
    .array_data(array_data), .flash_status_protection(flash_status_protection));
  flash_host u_flash_host (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  always #10 clk = ~clk;

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Go pulse counters and hang guard; the sweep needs about 9000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (array_write_go === 1'b1) n_wr <= n_wr + 1;
    if (array_sector_erase_go === 1'b1) n_se <= n_se + 1;
    if (array_bulk_erase_go === 1'b1) n_be <= n_be + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Command helpers and expected protection map for eight sectors
  // ---------------------------------------------------------------
  task automatic cmd(input logic [7:0] op, input logic [31:0] rest, input int n);
    u_flash_host.xfer({op, rest}, n, rx);
  endtask
  task automatic wr_status(input logic [7:0] v);
    cmd(OP_WR_EN, 32'h0, 8);  // Permit always precedes the status write
    cmd(OP_WR_STATUS, {v, 24'h0}, 16);
    #1000;  // Self-timed update of twenty cycles plus sync slack
  endtask
  function automatic bit prot(input logic [2:0] f, input bit t, input int s);
    int n;
    n = 1 << (f - 1);
    if (f == 3'h0) return 0;
    if (f[2]) return 1;
    return t ? (s < n) : (s >= 8 - n);
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    array_busy = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("reset status", flash_status_protection, 8'h00);
    check("idle output enable", serial_data_oe, 1'b0);
    // Status write without permit must be dropped
    cmd(OP_WR_STATUS, {8'h1C, 24'h0}, 16);
    #1000;
    check("unpermitted write", flash_status_protection, 8'h00);
    cmd(OP_WR_EN, 32'h0, 8);
    check("permit set", flash_status_protection[WEL_BIT], 1'b1);
    // Serial read taken inside the self-timed update shows busy
    cmd(OP_WR_STATUS, {8'h0C, 24'h0}, 16);
    cmd(OP_RD_STATUS, 32'h0, 24);
    check("busy during update", rx[15:8], 8'h01);
    #1000;
    cmd(OP_RD_STATUS, 32'h0, 24);
    check("repeated read", rx, 16'h0C0C);
    // Array cycle in progress: busy shows and commands are dropped
    @(posedge clk) array_busy <= 1'b1;
    repeat (3) @(posedge clk);
    check("array busy", flash_status_protection[WIP_BIT], 1'b1);
    cmd(OP_WR_EN, 32'h0, 8);
    check("enable while busy", flash_status_protection[WEL_BIT], 1'b0);
    @(posedge clk) array_busy <= 1'b0;
    // Write disable withdraws a permit that was just granted
    cmd(OP_WR_EN, 32'h0, 8);
    cmd(OP_WR_DIS, 32'h0, 8);
    check("permit withdrawn", flash_status_protection[WEL_BIT], 1'b0);
    // Every anchor and size code against every sector, writes on even sectors and erases on odd
    for (int t = 0; t < 2; t++) begin
      for (int f = 0; f < 8; f++) begin
        wr_status({2'b00, t[0], f[2:0], 2'b00});  // Reserved bits kept zero
        check("fields", flash_status_protection, {2'b00, t[0], f[2:0], 2'b00});
        for (int s = 0; s < 8; s++) begin
          cmd(OP_WR_EN, 32'h0, 8);
          if (s[0]) cmd(OP_ERASE_SECTOR, {s[7:0], 24'h0}, 32);
          else cmd(OP_WR_BYTES, {s[7:0], 16'h0, 8'hA5}, 40);
          e_wr += (!s[0] && !prot(f[2:0], t[0], s));
          e_se += (s[0] && !prot(f[2:0], t[0], s));
          check("writes", n_wr, e_wr);
          check("sector erases", n_se, e_se);
          check("permit used", flash_status_protection[WEL_BIT], 1'b0);
          if (!prot(f[2:0], t[0], s))
            check("address", array_addr, {s[7:0], 16'h0});
          if (!s[0] && !prot(f[2:0], t[0], s)) check("data", array_data, 8'hA5);
        end
        cmd(OP_WR_EN, 32'h0, 8);
        cmd(t[0] ? OP_ERASE_DIE : OP_ERASE_BULK, 32'h0, 8);
        e_be += (f == 0);
        check("bulk erases", n_be, e_be);
      end
    end
    results();
  end
endmodule  // testbench
`default_nettype wire

// ===== verilog/flash_sp_pkg.sv
// Constants shared by the status register and block protection logic
package flash_sp_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int WS_TIME_US = 10000;
  localparam int WS_CYCLES = WS_TIME_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------
  localparam int TB_BIT = 5;
  localparam int BP_HI = 4;
  localparam int BP_LO = 2;
  localparam int WEL_BIT = 1;
  localparam int WIP_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_WR_BYTES = 8'h02;
  localparam logic [7:0] OP_ERASE_SECTOR = 8'hD8;
  localparam logic [7:0] OP_ERASE_BULK = 8'hC7;
  localparam logic [7:0] OP_ERASE_DIE = 8'hC4;
  // ---------------------------------------------------------------
  // Frame lengths in serial clocks
  // ---------------------------------------------------------------
  localparam logic [5:0] LEN_OP = 6'h08;
  localparam logic [5:0] LEN_WRSR = 6'h10;
  localparam logic [5:0] LEN_SE = 6'h20;
  localparam logic [5:0] LEN_WR = 6'h28;
  localparam logic [5:0] CNT_WRAP = 6'h2F;
  localparam int SECTOR_LSB = 16;
  // ---------------------------------------------------------------
  // Densities and the field code that shields everything
  // ---------------------------------------------------------------
  localparam int DENS_S = 8;
  localparam int DENS_M = 32;
  localparam int DENS_L = 64;
  localparam logic [2:0] ALL_S = 3'h4;
  localparam logic [2:0] ALL_M = 3'h6;
  localparam logic [2:0] ALL_L = 3'h7;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WS = 2'b10} ws_state_t;
endpackage

// ===== verilog/flash_status_block_protect.sv
// Status register, serial command front end and sector protection gate
//
// Function
// RULE1 - Bits 7 and 6 reserved, reset zero; host never sets them.
// RULE2 - Bit 5 picks bottom (1) or top (0) anchoring, reset zero.
// RULE3 - Bits 4..2 size the protected region, writable, reset zero.
// RULE4 - Bit 1 write permit; clear rejects writes, status writes and erases.
// RULE5 - Bit 0 busy while status write, byte write or erase runs.
// RULE6 - Status readable any time, repeated while the host keeps clocking.
// RULE7 - Bulk and die erase only when size field is zero.
// RULE8 - Writes and sector erases into the protected region are rejected.
// RULE9 - 8 sectors: 000 none, top bit all, else 1/2/4 sectors.
// RULE10 - 32 sectors: codes 1..5 give 1..16 sectors; 110, 111 all.
// RULE11 - 64 sectors top: codes 1..6 give 1..32 sectors at 63; 111 all.
// RULE12 - Host enables writes first; status write data leaves bits 1, 0.
// RULE13 - Status write runs self-timed after select rises, busy meanwhile.
// RULE14 - Memory access during a running cycle is rejected, cycle continues.
// RULE15 - 64 sectors bottom: codes 1..6 give sectors 0 up; 111 all.
// RULE16 - Density is an elaboration parameter choosing the decode map.
// RULE17 - Status byte goes out MSB first.
`timescale 1ns/100ps
`default_nettype none
module flash_status_block_protect #(
  parameter int SECTORS = flash_sp_pkg::DENS_S,
  parameter int WS_CYCLES_P = flash_sp_pkg::WS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic array_busy,
  output logic array_write_go,
  output logic array_sector_erase_go,
  output logic array_bulk_erase_go,
  output logic [23:0] array_addr,
  output logic [7:0] array_data,
  output logic [7:0] flash_status_protection
);
  import flash_sp_pkg::*;
  localparam int SEC_W = $clog2(SECTORS);
  localparam int WS_W = $clog2(WS_CYCLES_P + 1);
  localparam logic [SEC_W:0] SEC_TOTAL = (SEC_W + 1)'(SECTORS);
  // Density chooses the code that shields the whole array [RULE16]
  localparam logic [2:0] ALL_CODE = (SECTORS == DENS_S) ? ALL_S :
                                    (SECTORS == DENS_M) ? ALL_M : ALL_L;
  if (WS_CYCLES_P < 2 || !(SECTORS inside {DENS_S, DENS_M, DENS_L})) begin : g_bad_param
    $error("SECTORS must be 8, 32 or 64 and WS_CYCLES_P at least 2");
  end
  // ---------------------------------------------------------------
  // Link side, on the host's serial clock
  // ---------------------------------------------------------------
  logic in_frame_ff, rd_mode_ff, nxt_rd_mode, out_ff, nxt_out, oe_ff, nxt_oe;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [39:0] sh_ff, nxt_sh;
  logic [7:0] stat_s1_ff, stat_s2_ff, lat_ff, nxt_lat, status_ff, nxt_status;
  // Frame marker; select high clears it so the next frame restarts the count
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      in_frame_ff <= 1'b0;
    end else begin
      in_frame_ff <= 1'b1;
    end
  end

  // Bit count wraps inside 40..47 so byte boundaries stay visible
  always_comb begin
    nxt_cnt = !in_frame_ff ? 6'h01 : (cnt_ff == CNT_WRAP) ? LEN_WR : cnt_ff + 6'h01;
    nxt_sh = (!in_frame_ff || cnt_ff < LEN_WR) ? {sh_ff[38:0], serial_data_in} : sh_ff;
    nxt_rd_mode = rd_mode_ff;
    if (!in_frame_ff) begin
      nxt_rd_mode = 1'b0;
    end else if (cnt_ff == LEN_OP - 6'h01) begin
      nxt_rd_mode = ({sh_ff[6:0], serial_data_in} == OP_RD_STATUS); // [RULE6]
    end
  end

  // Count and shifter keep their last frame for the system side to read
  always_ff @(posedge serial_clock) begin
    cnt_ff <= nxt_cnt;
    sh_ff <= nxt_sh;
    rd_mode_ff <= nxt_rd_mode;
    stat_s1_ff <= status_ff;
    stat_s2_ff <= stat_s1_ff;
  end

  // Status byte reloads at each byte start, so reads repeat endlessly
  always_comb begin
    nxt_oe = rd_mode_ff; // [RULE6]
    nxt_lat = (cnt_ff[2:0] == 3'h0) ? stat_s2_ff : lat_ff;
    nxt_out = nxt_lat[3'h7 - cnt_ff[2:0]]; // [RULE17]
  end

  // Output changes on the falling edge, half a clock ahead of host sampling
  always_ff @(negedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      oe_ff <= 1'b0;
      out_ff <= 1'b0;
      lat_ff <= STATUS_RESET;
    end else begin
      oe_ff <= nxt_oe;
      out_ff <= nxt_out;
      lat_ff <= nxt_lat;
    end
  end

  assign serial_data_out = out_ff;
  assign serial_data_oe = oe_ff;

  // ---------------------------------------------------------------
  // System side: frame end detect and command decode
  // ---------------------------------------------------------------
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff, frame_end, addr_prot, busy;
  logic [7:0] op;
  logic [23:0] addr;
  // Select passes three flops; frame contents are quiet once it is high
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= chip_select_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end
  assign frame_end = cs_s2_ff & ~cs_s3_ff;

  // Opcode position depends on how many bits the frame held
  always_comb begin
    case (cnt_ff)
      LEN_OP: op = sh_ff[7:0];
      LEN_WRSR: op = sh_ff[15:8];
      LEN_SE: op = sh_ff[31:24];
      default: op = (cnt_ff >= LEN_WR && cnt_ff[2:0] == 3'h0) ? sh_ff[39:32] : 8'h00;
    endcase
    addr = (cnt_ff >= LEN_WR) ? sh_ff[31:8] : sh_ff[23:0];
  end

  // Protected range: n sectors from the top or bottom, n doubling per code
  function automatic logic prot_hit(input logic tb, input logic [2:0] bp,
                                    input logic [SEC_W-1:0] sec);
    logic [SEC_W:0] n;
    n = (SEC_W + 1)'(1) << (bp - 3'h1);
    if (bp == 3'h0) begin
      prot_hit = 1'b0; // [RULE9] [RULE10] [RULE11]
    end else if (bp >= ALL_CODE) begin
      prot_hit = 1'b1; // [RULE9] [RULE10] [RULE11] [RULE15]
    end else if (tb) begin
      prot_hit = {1'b0, sec} < n; // [RULE2] [RULE15]
    end else begin
      prot_hit = {1'b0, sec} >= SEC_TOTAL - n; // [RULE2] [RULE11]
    end
  endfunction

  // ---------------------------------------------------------------
  // System side: status bits and self-timed status write
  // ---------------------------------------------------------------
  ws_state_t state_ff, nxt_state;
  logic [WS_W-1:0] ws_cnt_ff, nxt_ws_cnt;
  logic [5:0] cfg_ff, nxt_cfg, pend_ff, nxt_pend;
  logic wel_ff, nxt_wel, wr_go_ff, nxt_wr_go, se_go_ff, nxt_se_go, be_go_ff, nxt_be_go;
  logic [23:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  assign addr_prot = prot_hit(cfg_ff[TB_BIT-2], cfg_ff[BP_HI-2:BP_LO-2],
                              addr[SECTOR_LSB +: SEC_W]);
  assign busy = (state_ff == ST_WS) | array_busy; // [RULE5]

  // Commands act on the frame end; only a status read survives busy
  always_comb begin
    nxt_state = state_ff;
    nxt_ws_cnt = ws_cnt_ff;
    nxt_cfg = cfg_ff;
    nxt_pend = pend_ff;
    nxt_wel = wel_ff;
    nxt_wr_go = 1'b0;
    nxt_se_go = 1'b0;
    nxt_be_go = 1'b0;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    case (state_ff)
      ST_IDLE: begin
        if (frame_end && !busy) begin // [RULE14]
          case (op)
            OP_WR_EN: nxt_wel = 1'b1;
            OP_WR_DIS: nxt_wel = 1'b0;
            OP_WR_STATUS: begin
              if (wel_ff) begin // [RULE4]
                nxt_pend = sh_ff[7:2]; // [RULE3] [RULE12]
                nxt_wel = 1'b0;
                nxt_ws_cnt = '0;
                nxt_state = ST_WS; // [RULE13]
              end
            end
            OP_WR_BYTES, OP_ERASE_SECTOR: begin
              if (wel_ff) begin // [RULE4]
                nxt_wel = 1'b0;
                nxt_addr = addr;
                nxt_data = sh_ff[7:0];
                nxt_wr_go = (op == OP_WR_BYTES) && !addr_prot; // [RULE8]
                nxt_se_go = (op == OP_ERASE_SECTOR) && !addr_prot; // [RULE8]
              end
            end
            OP_ERASE_BULK, OP_ERASE_DIE: begin
              if (wel_ff) begin // [RULE4]
                nxt_wel = 1'b0;
                nxt_be_go = (cfg_ff[BP_HI-2:BP_LO-2] == 3'h0); // [RULE7]
              end
            end
            default: nxt_wel = wel_ff;
          endcase
        end
      end
      ST_WS: begin
        nxt_ws_cnt = ws_cnt_ff + WS_W'(1);
        if (ws_cnt_ff == WS_W'(WS_CYCLES_P - 1)) begin
          nxt_cfg = pend_ff; // [RULE13]
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_status = {nxt_cfg, nxt_wel, (nxt_state == ST_WS) | array_busy}; // [RULE5]
  end

  // Control state returns to zero on reset, except state_ff which loads ST_IDLE (2'b01)
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      ws_cnt_ff <= '0;
      cfg_ff <= STATUS_RESET[7:2]; // [RULE1] [RULE2] [RULE3]
      pend_ff <= STATUS_RESET[7:2];
      wel_ff <= 1'b0;
      wr_go_ff <= 1'b0;
      se_go_ff <= 1'b0;
      be_go_ff <= 1'b0;
      addr_ff <= '0;
      data_ff <= '0;
      status_ff <= STATUS_RESET;
    end else begin
      state_ff <= nxt_state;
      ws_cnt_ff <= nxt_ws_cnt;
      cfg_ff <= nxt_cfg;
      pend_ff <= nxt_pend;
      wel_ff <= nxt_wel;
      wr_go_ff <= nxt_wr_go;
      se_go_ff <= nxt_se_go;
      be_go_ff <= nxt_be_go;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      status_ff <= nxt_status;
    end
  end

  assign array_write_go = wr_go_ff;
  assign array_sector_erase_go = se_go_ff;
  assign array_bulk_erase_go = be_go_ff;
  assign array_addr = addr_ff;
  assign array_data = data_ff;
  assign flash_status_protection = status_ff;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_WEL_GATE: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    (wr_go_ff || se_go_ff || be_go_ff || $rose(state_ff == ST_WS)) |-> $past(wel_ff) && !wel_ff)
    else $error("write or erase started without write permit");
  AST_BULK_ZERO: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    be_go_ff |-> $past(cfg_ff[BP_HI-2:BP_LO-2]) == 3'h0)
    else $error("bulk erase with protection set");
  AST_PROT_BLOCK: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    (wr_go_ff || se_go_ff) |-> !$past(addr_prot))
    else $error("protected sector written or erased");
  AST_BUSY_REJECT: assert property (@(posedge clk) disable iff (rst) // [RULE14]
    (wr_go_ff || se_go_ff || be_go_ff) |-> !$past(busy))
    else $error("memory access accepted while busy");
  AST_WS_BUSY: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    $rose(state_ff == ST_WS) |-> status_ff[WIP_BIT] ##1 status_ff[WIP_BIT])
    else $error("busy flag not raised during status write");
  AST_WS_DONE: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    (state_ff == ST_WS && ws_cnt_ff == WS_W'(WS_CYCLES_P - 1)) |=>
      state_ff == ST_IDLE && cfg_ff == $past(pend_ff))
    else $error("status write did not finish on time");
  AST_NONE_CODE: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    (cfg_ff[BP_HI-2:BP_LO-2] == 3'h0) |-> !addr_prot)
    else $error("sector protected with empty field");
  AST_ALL_CODE: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    (cfg_ff[BP_HI-2:BP_LO-2] == 3'h7) |-> addr_prot)
    else $error("sector open with full protection code");
  AST_RD_OE: assert property (@(posedge serial_clock) disable iff (chip_select_n) // [RULE6]
    (in_frame_ff && rd_mode_ff && cnt_ff > LEN_OP) |-> oe_ff)
    else $error("status read output not enabled");
  AST_MSB_FIRST: assert property (@(negedge serial_clock) disable iff (chip_select_n) // [RULE17]
    (oe_ff && cnt_ff[2:0] == 3'h1) |-> out_ff == lat_ff[7])
    else $error("status byte not sent MSB first");
endmodule // flash_status_block_protect
`default_nettype wire
